// file: design/dsw_consts.vh
// constants for the dac serial write host controller
`ifndef DSW_CONSTS_VH
`define DSW_CONSTS_VH
`define DSW_WORD_BITS      19
`define DSW_CHAN_BITS      5
`define DSW_LEVEL_BITS     14
`define DSW_CHAN_MSB       18
`define DSW_LEVEL_MSB      13
`define DSW_PAD_BITS       24
`define DSW_BYTE_BITS      8
`define DSW_BYTES          3
`define DSW_SCLK_HALF      4
`define DSW_CLK_NS         10
`define DSW_GAP_NS         280
`define DSW_GAP_CYC        ((`DSW_GAP_NS + `DSW_CLK_NS - 1) / `DSW_CLK_NS)
`define DSW_FIFO_DEPTH     32
`define DSW_FIFO_AW        5
`endif

// file: design/dsw_fifo.v
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module dsw_fifo #(
  parameter WIDTH = 19,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk_sys,  // system clock
  input  wire             rstn,     // async reset, active low
  input  wire [WIDTH-1:0] inData,   // write data
  input  wire             inValid,  // write request
  output wire             inReady,  // space available
  output wire [WIDTH-1:0] outData,  // head word
  output wire             outValid, // head valid
  input  wire             outReady  // head consumed
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wrPtr_q;
  reg [AW:0]      rdPtr_q;
  wire            doWr;
  wire            doRd;

  // full when pointers differ only in wrap bit
  assign inReady  = (wrPtr_q ^ rdPtr_q) != {1'b1, {AW{1'b0}}};
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData  = mem[rdPtr_q[AW-1:0]];
  assign doWr     = inValid & inReady;
  assign doRd     = outValid & outReady;

  // storage array
  always @(posedge clk_sys) begin
    if (doWr)
      mem[wrPtr_q[AW-1:0]] <= inData;
  end

  // pointers
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= {(AW+1){1'b0}};
      rdPtr_q <= {(AW+1){1'b0}};
    end else begin
      if (doWr)
        wrPtr_q <= wrPtr_q + 1'b1;
      if (doRd)
        rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
endmodule

// file: design/dsw_host.v
// host controller driving the dac three-wire serial write port
//
// Behaviour
// - the serial clock idles low between transfers.
// - the word goes out as three back-to-back bytes inside one frame.
// - each word is sent most significant bit first, channel bit 4 first.
// - the 19-bit word is left aligned in 24 bits, trailing bits padding.
// - frame sync goes low before any data bit is shifted.
// - frame sync returns high and goes low again between writes.
// - a shift clock synchronous to the data is always supplied.
// - data changes one cycle after the rising edge, so no clock inversion is needed.
// - bits leave msb first from the shifter, no reversal needed.
// - the device input is enabled only while frame sync is held low.
// - a word is a 5-bit channel select then a 14-bit level code.
// - at least 280 ns pass between the end of a write and the next start.
`timescale 1ns/1ps
`include "dsw_consts.vh"
module dsw_host (
  input  wire                        clk_sys,      // 100 mhz system clock
  input  wire                        rstn,         // async reset, active low
  input  wire [`DSW_CHAN_BITS-1:0]   channelSelect,// target channel
  input  wire [`DSW_LEVEL_BITS-1:0]  levelCode,    // level for channel
  input  wire                        reqValid,     // write request
  output wire                        reqReady,     // fifo has room
  output wire                        busy,         // frame or queue active
  output reg                         syncN,        // frame sync, active low
  output reg                         sclk,         // serial clock
  output reg                         dataOut       // serial data
);
  // frame sequencer states
  localparam ST_IDLE  = 2'd0;
  localparam ST_SHIFT = 2'd1;
  localparam ST_END   = 2'd2;
  localparam ST_GAP   = 2'd3;
  // counts as plain integers, then cut to the counter widths
  localparam integer GAP_I   = `DSW_GAP_CYC;
  localparam integer HALF_I  = `DSW_SCLK_HALF - 1;
  localparam integer LAST_I  = `DSW_PAD_BITS - 1;
  localparam [8:0]   GAP_CYC = GAP_I[8:0];
  localparam [2:0]   HALF    = HALF_I[2:0];
  localparam [4:0]   LAST    = LAST_I[4:0];

  // fifo head and sequencer state
  wire [`DSW_WORD_BITS-1:0] fifoData;
  wire                      fifoValid;
  reg                       fifoPop;
  reg  [1:0]                state_q;
  reg  [2:0]                divCnt_q;
  reg  [4:0]                bitCnt_q;
  reg  [8:0]                gapCnt_q;
  reg  [`DSW_PAD_BITS-1:0]  shift_q;

  // next values of the sequencer flops
  reg  [1:0]                state_d;
  reg  [2:0]                divCnt_d;
  reg  [4:0]                bitCnt_d;
  reg  [8:0]                gapCnt_d;
  reg  [`DSW_PAD_BITS-1:0]  shift_d;
  reg                       syncN_d;
  reg                       sclk_d;
  reg                       dataOut_d;

  // decoded sequencer conditions
  wire                      halfDone;
  wire                      lastFall;
  wire                      gapDone;
  wire                      launchBit;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  // word packing: channel first, then level code
  function [`DSW_PAD_BITS-1:0] packWord;
    input [`DSW_WORD_BITS-1:0] w;
    begin
      packWord = {w, {(`DSW_PAD_BITS-`DSW_WORD_BITS){1'b0}}};
    end
  endfunction

  // bit that the shifter presents to the link next
  function topBit;
    input [`DSW_PAD_BITS-1:0] s;
    begin
      topBit = s[`DSW_PAD_BITS-1];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // request queue
  dsw_fifo #(
    .WIDTH (`DSW_WORD_BITS),
    .DEPTH (`DSW_FIFO_DEPTH),
    .AW    (`DSW_FIFO_AW)
  ) uFifo (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .inData   ({channelSelect, levelCode}),
    .inValid  (reqValid),
    .inReady  (reqReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  // pop when a frame is launched
  always @* begin
    fifoPop = (state_q == ST_IDLE) & fifoValid;
  end

  // busy while a word waits or a frame or gap is running
  assign busy = (state_q != ST_IDLE) | fifoValid;

  ////////////////////////////////////////////////////////////////////////
  // sequencer conditions
  // one half period of the serial clock has elapsed
  assign halfDone  = (divCnt_q == HALF);
  // this fall is the 24th and last of the frame
  assign lastFall  = (bitCnt_q == LAST);
  // frame sync has stood high for the minimum gap
  assign gapDone   = (gapCnt_q == GAP_CYC - 9'd1);
  // one cycle after the rising edge: safe point to move data
  assign launchBit = sclk & (divCnt_q == 3'd0);

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer and clock divider, next-state decode
  always @* begin
    state_d   = state_q;
    divCnt_d  = divCnt_q;
    bitCnt_d  = bitCnt_q;
    gapCnt_d  = gapCnt_q;
    shift_d   = shift_q;
    syncN_d   = syncN;
    sclk_d    = sclk;
    dataOut_d = dataOut;
    case (state_q)
      ST_IDLE: begin
        // clock parked low, launch as soon as a word waits
        sclk_d = 1'b0;
        if (fifoValid) begin
          shift_d   = packWord(fifoData);
          dataOut_d = topBit(packWord(fifoData));
          syncN_d   = 1'b0;
          divCnt_d  = 3'd0;
          bitCnt_d  = 5'd0;
          state_d   = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        // one bit per 2*(HALF+1) cycles, 24 bits continuous (3 bytes)
        if (halfDone) begin
          divCnt_d = 3'd0;
          if (!sclk) begin
            sclk_d = 1'b1;
          end else begin
            // device takes the top bit here; drop it afterwards
            sclk_d = 1'b0;
            if (lastFall) begin
              state_d = ST_END;
            end else begin
              bitCnt_d = bitCnt_q + 5'd1;
              shift_d  = {shift_q[`DSW_PAD_BITS-2:0], 1'b0};
            end
          end
        end else begin
          divCnt_d = divCnt_q + 3'd1;
          // the bit for the coming fall goes out after the rise
          if (launchBit)
            dataOut_d = topBit(shift_q);
        end
      end
      ST_END: begin
        // hold sync for one half period after the last fall
        if (halfDone) begin
          syncN_d  = 1'b1;
          gapCnt_d = 9'd0;
          state_d  = ST_GAP;
        end else begin
          divCnt_d = divCnt_q + 3'd1;
        end
      end
      ST_GAP: begin
        // sync high for the minimum gap before the next launch
        if (gapDone)
          state_d  = ST_IDLE;
        else
          gapCnt_d = gapCnt_q + 9'd1;
      end
      default: begin
        state_d = ST_IDLE;
        syncN_d = 1'b1;
        sclk_d  = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer registers, link outputs straight from flops
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q  <= ST_IDLE;
      divCnt_q <= 3'd0;
      bitCnt_q <= 5'd0;
      gapCnt_q <= 9'd0;
      shift_q  <= {`DSW_PAD_BITS{1'b0}};
      syncN    <= 1'b1;
      sclk     <= 1'b0;
      dataOut  <= 1'b0;
    end else begin
      state_q  <= state_d;
      divCnt_q <= divCnt_d;
      bitCnt_q <= bitCnt_d;
      gapCnt_q <= gapCnt_d;
      shift_q  <= shift_d;
      syncN    <= syncN_d;
      sclk     <= sclk_d;
      dataOut  <= dataOut_d;
    end
  end
endmodule

// file: testbench/dsw_host_properties.sv
// port assertions for the host controller
`timescale 1ns/1ps
module dsw_host_properties (
  input wire clk_sys,  // clock
  input wire rstn,     // reset
  input wire reqValid, // request
  input wire reqReady, // room
  input wire busy,     // active
  input wire syncN,    // frame sync
  input wire sclk,     // serial clock
  input wire dataOut   // serial data
);
  reg [5:0] gapQ;
  reg [4:0] fallQ;
  reg       sclkQ;
  // sync high cycles and clock falls per frame
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gapQ <= 6'h3f;
      fallQ <= 5'h00;
      sclkQ <= 1'b0;
    end else begin
      sclkQ <= sclk;
      gapQ <= !syncN ? 6'h00 : gapQ + {5'h00, gapQ != 6'h3f};
      fallQ <= syncN ? 5'h00 : fallQ + {4'h0, sclkQ & !sclk};
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_push; reqValid && reqReady && !busy; endsequence
  sequence s_launch; ##[1:2] $fell(syncN); endsequence
  sequence s_fall; !syncN && sclkQ && !sclk; endsequence
  a_launch_time: assert property (s_push |-> s_launch)
    else $error("late frame");
  a_sclk_idle: assert property (syncN |-> !sclk)
    else $error("clock not idle");
  a_sync_first: assert property ($fell(syncN) |-> !sclk [*4])
    else $error("early clock");
  a_data_stable: assert property ($fell(sclk) |-> $stable(dataOut))
    else $error("data moved at fall");
  a_data_rise: assert property
    (!syncN && !$fell(syncN) && $changed(dataOut) |-> sclk)
    else $error("data moved while low");
  a_frame_bits: assert property ($rose(syncN) |-> fallQ == 5'd24)
    else $error("bad bit count");
  a_pad_zero: assert property (s_fall ##0 fallQ >= 5'd19 |-> !dataOut)
    else $error("pad not zero");
  a_gap_min: assert property ($fell(syncN) |-> gapQ >= 6'd28)
    else $error("gap short");
  a_busy_frame: assert property (!syncN |-> busy)
    else $error("idle in frame");
endmodule
bind dsw_host dsw_host_properties u_props (.clk_sys(clk_sys), .rstn(rstn),
  .reqValid(reqValid), .reqReady(reqReady), .busy(busy), .syncN(syncN),
  .sclk(sclk), .dataOut(dataOut));

// file: testbench/dsw_dac_model.sv
// behavioural model of the dac serial write port
`timescale 1ns/1ps
module dsw_dac_model (
  input  wire        rstn,   // device reset
  input  wire        syncN,  // frame sync
  input  wire        sclk,   // serial clock
  input  wire        dataIn, // serial data
  output reg  [4:0]  chanQ,  // loaded channel
  output reg  [13:0] levelQ, // loaded level
  output reg         loadTgl // flips per load
);
  reg [18:0] shiftQ;
  reg [4:0]  cntQ;
  reg        syncQ;
  // shift in at clock falls within a frame
  always @(negedge rstn or syncN or negedge sclk) begin
    if (!rstn) begin
      cntQ = 5'd19;
      loadTgl = 1'b0;
    end else if (syncN !== syncQ) begin
      if (!syncN && cntQ == 5'd19) cntQ = 5'd0;
    end else if (!syncN && cntQ < 5'd19) begin
      shiftQ = {shiftQ[17:0], dataIn};
      cntQ = cntQ + 5'd1;
      if (cntQ == 5'd19) begin
        {chanQ, levelQ} = shiftQ;
        loadTgl = ~loadTgl;
      end
    end
    syncQ = syncN;
  end
endmodule

// file: testbench/dsw_host_bench.sv
// self-checking bench for the dac serial write host
`timescale 1ns/1ps
module dsw_host_bench;
  reg        clk_sys = 1'b0;
  reg        rstn = 1'b0;
  reg [4:0]  channelSelect = 5'h00;
  reg [13:0] levelCode = 14'h0000;
  reg        reqValid = 1'b0;
  reg        sawFull = 1'b0;
  reg [31:0] r;
  reg [18:0] expQ[$];
  wire       reqReady, busy, syncN, sclk, dataOut, loadTgl;
  wire [4:0] chanQ;
  wire [13:0] levelQ;
  integer    fail_count = 0, check_count = 0, cycles = 0, i;
  dsw_host uut (.clk_sys(clk_sys), .rstn(rstn), .channelSelect(channelSelect),
    .levelCode(levelCode), .reqValid(reqValid), .reqReady(reqReady),
    .busy(busy), .syncN(syncN), .sclk(sclk), .dataOut(dataOut));
  dsw_dac_model dac (.rstn(rstn), .syncN(syncN), .sclk(sclk),
    .dataIn(dataOut), .chanQ(chanQ), .levelQ(levelQ), .loadTgl(loadTgl));
  task check(input [18:0] seen, input [18:0] exp, input string what);
    check_count = check_count + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value %0s exp %h seen %h", what, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hold a request until the fifo takes it
  task send(input [4:0] ch, input [13:0] lv);
    channelSelect <= ch;
    levelCode <= lv;
    reqValid <= 1'b1;
    @(posedge clk_sys);
    while (!reqReady) begin
      sawFull = 1'b1;
      @(posedge clk_sys);
    end
    expQ.push_back({ch, lv});
  endtask
  task drain;
    reqValid <= 1'b0;
    @(posedge clk_sys);
    while (busy) @(posedge clk_sys);
    check(expQ.size(), 19'h0, "left");
  endtask
  // each device load against the oldest note
  always @(loadTgl) if (rstn) begin
    if (expQ.size() == 0) check(19'h7ffff, 19'h0, "extra");
    else check({chanQ, levelQ}, expQ.pop_front(), "word");
  end
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      fail_count = fail_count + 1;
      tally_and_finish;
    end
  end
  initial forever #5 clk_sys = ~clk_sys;
  initial begin
    r = $urandom(13042);
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    check({syncN, sclk, dataOut, reqReady, busy}, 19'h12, "rst");
    send(5'h00, 14'h0000);
    send(5'h1f, 14'h3fff);
    for (i = 0; i < 40; i = i + 1) begin
      r = $urandom;
      send(r[4:0], r[18:5]);
    end
    drain;
    check({18'h0, sawFull}, 19'h1, "full");
    send(5'h15, 14'h2aaa);
    reqValid <= 1'b0;
    repeat (60) @(posedge clk_sys);
    rstn <= 1'b0;
    expQ.delete();
    repeat (3) @(posedge clk_sys);
    check({syncN, sclk, dataOut, reqReady, busy}, 19'h12, "rst2");
    rstn <= 1'b1;
    send(5'h0a, 14'h1555);
    drain;
    tally_and_finish;
  end
endmodule
